// ---- hw/event_timer_params.svh ----
// Register indices, field positions and reset values of the timer block
`ifndef EVENT_TIMER_PARAMS_SVH
`define EVENT_TIMER_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_COUNT_A 6'h0d
`define IDX_CONTROL_A 6'h0e
`define IDX_COUNT_B 6'h10
`define IDX_CONTROL_B 6'h11
`define IDX_INTC 6'h0b

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_MODE_HI 7
`define CTL_MODE_LO 6
`define CTL_CLK_SRC 5
`define CTL_RUN 4
`define CTL_EDGE 3
`define CTL_PSC_HI 2
`define CTL_PSC_LO 0

// ----------------------------------------
// Interrupt control register fields
// ----------------------------------------
`define INTC_ENABLE 0
`define INTC_FLAG_A 5
`define INTC_FLAG_B 6
`define INTC_MASK 8'h61

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define CONTROL_RESET 8'h08
`define CONTROL_A_MASK 8'hff
`define CONTROL_B_MASK 8'hf8
`define QUARTER_DIV_MAX 2'h3

`endif

// ---- hw/event_timer_pkg.sv ----
// Types shared by the timer block
package event_timer_pkg;

	// ----------------------------------------
	// Operating modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_UNUSED = 2'b00,
		MODE_EVENT = 2'b01,
		MODE_TIMER = 2'b10,
		MODE_PULSE = 2'b11
	} timer_mode_t;

	// ----------------------------------------
	// Pulse-width measurement states
	// ----------------------------------------
	typedef enum logic {
		PW_ARMED = 1'b0,
		PW_COUNTING = 1'b1
	} pulse_state_t;

endpackage

// ---- hw/event_timer_pulse_measure.sv ----
// Two 8-bit timer/event counters with pulse-width measurement
// Operation
// - Each channel is an 8-bit up-counter
// - Write goes to preload; read returns counter
// - Control bits 7:6 select operating mode
// - Event mode pin edges; timer and pulse modes prescaled clock
// - Overflow reloads preload and sets flag
// - Overflow flags at interrupt bits 5, 6
// - Pulse mode counts between edges, clears run
// - Pulse measurement single-shot until run set
// - Pulse mode acts on edges, not levels
// - Pulse mode overflow reloads and flags too
// - Run bit software-only outside pulse mode
// - Overflow is a wake-up source
// - Enable clear blocks service, flag still sets
// - Stopped write loads counter; running preload only
// - Count clock blocked during counter read
// - Bits 2:0 divide timer A clock by two power; timer B masks them off
// - Bit 3 selects edge polarity
// - Bit 4 is the run bit
// - Bit 5 selects system or RTC clock
// - Overflows feed the buzzer signal source
// - Second timer uses system clock over four
//
// Added by the designer: the Wishbone register port.
`include "event_timer_params.svh"

module event_timer_pulse_measure #(
	parameter int COUNT_WIDTH = 8,
	parameter int PSC_WIDTH = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Timer pins and RTC clock
	input wire logic [1:0] timer_pin,
	input wire logic rtc_clock,
	// Events out
	output logic [1:0] overflow_event,
	output logic wake_request,
	output logic [1:0] buzzer_source,
	output logic [1:0] service_request
);
	import event_timer_pkg::*;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic timer_mode_t mode_of(input logic [7:0] ctl);
		return timer_mode_t'(ctl[`CTL_MODE_HI:`CTL_MODE_LO]);
	endfunction

	function automatic logic [PSC_WIDTH-1:0] psc_mask(
		input logic [2:0] sel);
		logic [PSC_WIDTH:0] one_hot;
		one_hot = '0;
		one_hot[sel] = 1'b1;
		return PSC_WIDTH'(one_hot - 1'b1);
	endfunction

	// ----------------------------------------
	// Bus request decode
	// ----------------------------------------
	logic [5:0] reg_index;
	logic bus_req;
	logic bus_write;
	logic [7:0] write_byte;
	logic [7:0] read_byte;
	logic [7:0] intc;
	logic [1:0][COUNT_WIDTH-1:0] count_bus;
	logic [1:0][7:0] control_bus;
	logic [1:0] overflow;

	assign reg_index = wb_adr_i[7:2];
	assign bus_req = wb_cyc_i & wb_stb_i;
	// Writes land only at the acknowledging edge
	assign bus_write = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign write_byte = wb_dat_i[7:0];

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_req & ~wb_ack_o;
	end

	always_comb
	begin
		read_byte = 8'h00;
		unique case (reg_index)
			`IDX_COUNT_A:
				read_byte = 8'(count_bus[0]);
			`IDX_CONTROL_A:
				read_byte = control_bus[0];
			`IDX_COUNT_B:
				read_byte = 8'(count_bus[1]);
			`IDX_CONTROL_B:
				read_byte = control_bus[1];
			`IDX_INTC:
				read_byte = intc;
			default:
				read_byte = 8'h00;
		endcase
	end

	// Unmapped indices still answer, reading as zero
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			wb_dat_o <= 32'h0000_0000;
		else if (bus_req & ~wb_ack_o)
			wb_dat_o <= {24'h00_0000, read_byte};
	end

	// ----------------------------------------
	// Interrupt control register
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			intc <= 8'h00;
		else
		begin
			if (bus_write && reg_index == `IDX_INTC)
				intc <= write_byte & `INTC_MASK;
			// A new overflow beats a clearing write
			if (overflow[0])
				intc[`INTC_FLAG_A] <= 1'b1;
			if (overflow[1])
				intc[`INTC_FLAG_B] <= 1'b1;
		end
	end

	// Flags always set; enable only gates servicing
	assign service_request = {intc[`INTC_FLAG_B], intc[`INTC_FLAG_A]}
		& {2{intc[`INTC_ENABLE]}};

	// ----------------------------------------
	// Shared clock sources
	// ----------------------------------------
	logic rtc_prev;
	logic rtc_tick;
	logic [1:0] quarter_cnt;
	logic quarter_tick;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			rtc_prev <= 1'b0;
		else
			rtc_prev <= rtc_clock;
	end

	assign rtc_tick = rtc_clock & ~rtc_prev;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			quarter_cnt <= 2'h0;
		else
			quarter_cnt <= quarter_cnt + 2'h1;
	end

	assign quarter_tick = (quarter_cnt == `QUARTER_DIV_MAX);

	// ----------------------------------------
	// Event outputs
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			overflow_event <= 2'b00;
			wake_request <= 1'b0;
		end
		else
		begin
			overflow_event <= overflow;
			wake_request <= |overflow;
		end
	end

	// Square wave halves the overflow rate for the buzzer
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			buzzer_source <= 2'b00;
		else
			buzzer_source <= buzzer_source ^ overflow;
	end

	// ----------------------------------------
	// Timer channels
	// ----------------------------------------
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_channel
		localparam logic [5:0] IDX_COUNT =
			(ch == 0) ? `IDX_COUNT_A : `IDX_COUNT_B;
		localparam logic [5:0] IDX_CONTROL =
			(ch == 0) ? `IDX_CONTROL_A : `IDX_CONTROL_B;
		localparam logic [7:0] CTL_MASK =
			(ch == 0) ? `CONTROL_A_MASK : `CONTROL_B_MASK;

		logic [7:0] control;
		logic [COUNT_WIDTH-1:0] count;
		logic [COUNT_WIDTH-1:0] preload;
		logic [PSC_WIDTH-1:0] psc_cnt;
		logic [PSC_WIDTH-1:0] mask;
		logic [2:0] pin_sync;
		pulse_state_t pw_state;
		pulse_state_t next_pw_state;
		timer_mode_t mode;
		logic run;
		logic edge_sel;
		logic pin_rise;
		logic pin_fall;
		logic count_edge;
		logic start_edge;
		logic src_tick;
		logic psc_tick;
		logic read_hold;
		logic advance;
		logic pw_stop;
		logic wr_count;
		logic wr_control;

		assign mode = mode_of(control);
		assign run = control[`CTL_RUN];
		assign edge_sel = control[`CTL_EDGE];
		assign wr_count = bus_write && reg_index == IDX_COUNT;
		assign wr_control = bus_write && reg_index == IDX_CONTROL;

		// Stage 0 feeds only stage 1; edges use stages 1 and 2
		always_ff @(posedge clk)
		begin
			if (!reset_n)
				pin_sync <= 3'b000;
			else
				pin_sync <= {pin_sync[1:0], timer_pin[ch]};
		end

		assign pin_rise = pin_sync[1] & ~pin_sync[2];
		assign pin_fall = ~pin_sync[1] & pin_sync[2];
		assign count_edge = edge_sel ? pin_fall : pin_rise;
		assign start_edge = edge_sel ? pin_rise : pin_fall;

		// Prescaler input: system clock (timer B: quarter clock tick) or RTC tick
		if (ch == 0)
		begin : g_src_a
			assign src_tick = control[`CTL_CLK_SRC] ? rtc_tick : 1'b1;
			assign mask = psc_mask(control[`CTL_PSC_HI:`CTL_PSC_LO]);
		end
		else
		begin : g_src_b
			assign src_tick = control[`CTL_CLK_SRC] ? rtc_tick
				: quarter_tick;
			assign mask = '0;
		end

		// Held clear while stopped so each run starts in phase
		always_ff @(posedge clk)
		begin
			if (!reset_n)
				psc_cnt <= '0;
			else if (!run)
				psc_cnt <= '0;
			else if (src_tick)
				psc_cnt <= psc_cnt + 1'b1;
		end

		assign psc_tick = src_tick & ((psc_cnt & mask) == mask);

		// Reading the counter drops its ticks for as long as the read request stands, through the ack cycle
		assign read_hold = bus_req & ~wb_we_i
			& (reg_index == IDX_COUNT);

		always_comb
		begin
			advance = 1'b0;
			unique case (mode)
				MODE_EVENT:
					advance = count_edge;
				MODE_TIMER:
					advance = psc_tick;
				MODE_PULSE:
					advance = psc_tick & (pw_state == PW_COUNTING);
				MODE_UNUSED:
					advance = 1'b0;
			endcase
			advance = advance & run & ~read_hold;
		end

		assign overflow[ch] = advance & (count == '1);
		assign pw_stop = (mode == MODE_PULSE) & run
			& (pw_state == PW_COUNTING) & count_edge;

		// Measurement arms again only once run is set
		always_comb
		begin
			next_pw_state = pw_state;
			unique case (pw_state)
				PW_ARMED:
					if (run && mode == MODE_PULSE && start_edge)
						next_pw_state = PW_COUNTING;
				PW_COUNTING:
					if (!run || mode != MODE_PULSE || pw_stop)
						next_pw_state = PW_ARMED;
			endcase
		end

		always_ff @(posedge clk)
		begin
			if (!reset_n)
				pw_state <= PW_ARMED;
			else
				pw_state <= next_pw_state;
		end

		// Software write wins over the hardware run clear
		always_ff @(posedge clk)
		begin
			if (!reset_n)
				control <= `CONTROL_RESET & CTL_MASK;
			else if (wr_control)
				control <= write_byte & CTL_MASK;
			else if (pw_stop)
				control[`CTL_RUN] <= 1'b0;
		end

		always_ff @(posedge clk)
		begin
			if (!reset_n)
				preload <= '0;
			else if (wr_count)
				preload <= COUNT_WIDTH'(write_byte);
		end

		always_ff @(posedge clk)
		begin
			if (!reset_n)
				count <= '0;
			else if (wr_count && !run)
				count <= COUNT_WIDTH'(write_byte);
			else if (overflow[ch])
				count <= preload;
			else if (advance)
				count <= count + 1'b1;
		end

		assign count_bus[ch] = count;
		assign control_bus[ch] = control;
	end

endmodule // event_timer_pulse_measure

// ---- dv/timer_props.sv ----
// Checker on the bus and event ports of the timer block
module timer_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Events
	input wire logic [1:0] overflow_event,
	input wire logic wake_request,
	input wire logic [1:0] buzzer_source
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	ack_answer_a: assert property (
		$rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o) else $error("no ack");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_cause_a: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
	dat_hold_a: assert property (
		$changed(wb_dat_o) |-> wb_ack_o) else $error("read data moved");
	dat_width_a: assert property (
		wb_dat_o[31:8] == 24'h00_0000) else $error("upper bits set");
	wake_src_a: assert property (
		wake_request |-> |overflow_event) else $error("wake alone");
	wake_all_a: assert property (
		|overflow_event |-> wake_request) else $error("wake missing");
	// Toggle may land with the event or one cycle later
	buzz_first_a: assert property (
		overflow_event[0] |-> ##[0:1] $changed(buzzer_source[0]))
		else $error("buzzer A idle");
	buzz_second_a: assert property (
		overflow_event[1] |-> ##[0:1] $changed(buzzer_source[1]))
		else $error("buzzer B idle");
	cover property (overflow_event[0]);
	cover property (overflow_event[1]);
	cover property (wb_ack_o);
endmodule // timer_props

bind event_timer_pulse_measure timer_props u_props (
	.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.overflow_event(overflow_event), .wake_request(wake_request),
	.buzzer_source(buzzer_source)
);

// ---- dv/pin_source.sv ----
// Far-side model driving the two timer input pins
module pin_source (
	// Clock
	input wire logic clk,
	// Pins
	output logic [1:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
		pin = 2'b00;
	task level(input int ch, input logic v);
		@(posedge clk);
		pin[ch] <= v;
	endtask
	// Width w sets a prompt or a slow source
	task pulse(input int ch, input int w);
		@(posedge clk);
		pin[ch] <= ~pin[ch];
		repeat (w) @(posedge clk);
		pin[ch] <= ~pin[ch];
		repeat (w) @(posedge clk);
	endtask
endmodule // pin_source

// ---- dv/event_timer_pulse_measure_bench.sv ----
// Self-checking bench for the two-channel timer block
module event_timer_pulse_measure_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, wb_ack_o, wake_request, rtc_clock = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
	logic [1:0] timer_pin, overflow_event, buzzer_source, service_request;
	int n_fail = 0, tests_run = 0, cycles = 0;

	always #5 clk = ~clk;

	event_timer_pulse_measure dut (
		.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .timer_pin(timer_pin), .rtc_clock(rtc_clock),
		.overflow_event(overflow_event), .wake_request(wake_request),
		.buzzer_source(buzzer_source), .service_request(service_request)
	);
	pin_source src (.clk(clk), .pin(timer_pin));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task end_sim;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task rng(input logic [11:0] v, input logic [11:0] lo, hi);
		tests_run++;
		if ((v >= lo && v <= hi) !== 1'b1)
		begin
			n_fail++;
			$display("CHECK FAILED %0t %h out of range", $time, v);
		end
	endtask
	// Request stands until ack is seen high at a rising edge
	task bus(input logic we, input logic [7:0] a, d, output logic [7:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h00_0000, d};
		wb_sel_i <= 4'h1;
		do
			@(posedge clk);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [7:0] a, d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, exp);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask
	task svc(input logic [1:0] exp);
		@(negedge clk);
		chk({6'h00, service_request}, {6'h00, exp});
		@(posedge clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		rd(8'h38, 8'h08);
		rd(8'h44, 8'h08);
		rd(8'h2C, 8'h00);
		wr(8'h3C, 8'hff);
		rd(8'h3C, 8'h00);
	endtask
	task t_timer;
		int t0;
		wr(8'h34, 8'hf0);
		rd(8'h34, 8'hf0);
		wr(8'h38, 8'h97);
		t0 = cycles;
		wr(8'h34, 8'h80);
		rd(8'h34, 8'hf0);
		do
			@(negedge clk);
		while (overflow_event[0] !== 1'b1);
		rng(12'(cycles - t0), 12'h780, 12'h880);
		@(posedge clk);
		rd(8'h34, 8'h80);
		rd(8'h38, 8'h97);
		rd(8'h2C, 8'h20);
		svc(2'b00);
		wr(8'h2C, 8'h21);
		svc(2'b01);
		wr(8'h38, 8'h00);
		wr(8'h2C, 8'h00);
	endtask
	task t_event;
		wr(8'h40, 8'hfe);
		wr(8'h44, 8'h50);
		repeat (3)
			src.pulse(1, 4);
		rd(8'h40, 8'hff);
		rd(8'h2C, 8'h40);
		wr(8'h2C, 8'h41);
		svc(2'b10);
		rd(8'h44, 8'h50);
	endtask
	// RTC ticks for timer A, quarter clock for timer B
	task t_rtc;
		logic [7:0] q;
		wr(8'h34, 8'hfe);
		wr(8'h38, 8'hb0);
		repeat (20) @(posedge clk);
		rd(8'h34, 8'hfe);
		rtc_clock <= 1'b1;
		repeat (4) @(posedge clk);
		rtc_clock <= 1'b0;
		repeat (4) @(posedge clk);
		rd(8'h34, 8'hff);
		wr(8'h38, 8'h00);
		wr(8'h44, 8'h80);
		wr(8'h40, 8'h00);
		wr(8'h44, 8'h90);
		repeat (40) @(posedge clk);
		bus(1'b0, 8'h40, 8'h00, q);
		rng({4'h0, q}, 12'h00a, 12'h00b);
		wr(8'h44, 8'h00);
	endtask
	task t_pulse;
		logic [7:0] q;
		src.level(0, 1'b1);
		wr(8'h34, 8'h00);
		wr(8'h38, 8'hd8);
		repeat (20) @(posedge clk);
		rd(8'h34, 8'h00);
		src.level(0, 1'b0);
		repeat (10) @(posedge clk);
		rd(8'h34, 8'h00);
		src.pulse(0, 40);
		bus(1'b0, 8'h34, 8'h00, q);
		rng({4'h0, q}, 12'h027, 12'h029);
		rd(8'h38, 8'hc8);
		src.pulse(0, 10);
		rd(8'h34, q);
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_timer;
		t_event;
		t_rtc;
		t_pulse;
		end_sim;
	end
	// Whole run needs about 2400 cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 10000)
		begin
			n_fail++;
			$display("CHECK FAILED %0t timeout", $time);
			end_sim;
		end
	end
endmodule // event_timer_pulse_measure_bench
